//--- hw/gpa_pkg.sv
// Constants shared by the port A block
package gpa_pkg;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_PIN_DATA = 8'h00;
    localparam logic [7:0] OFS_OUTPUT_ENABLE = 8'h04;
    localparam logic [7:0] OFS_FSEL_FIRST = 8'h08;
    localparam logic [7:0] OFS_FSEL_SECOND = 8'h0C;
    localparam logic [7:0] OFS_OPEN_DRAIN = 8'h28;
    localparam logic [7:0] OFS_PULL_UP = 8'h2C;
    localparam logic [7:0] OFS_PULL_DOWN = 8'h30;
    localparam logic [7:0] OFS_INPUT_ENABLE = 8'h38;
    localparam logic [7:0] OFS_STOP_CONTROL = 8'h40;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] FSEL_SECOND_MASK = 8'hF5;
    localparam logic [7:0] INT_PIN_MASK = 8'h85;
    localparam int STOP_DRIVE_BIT = 0;
    localparam int STOP_STATE_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- hw/gpa_pin_mux.sv
// Per-pin function selection, drive and input gating
`timescale 1ns/1ns
module gpa_pin_mux (
    input wire logic [gpa_pkg::PORT_W-1:0] data_bits,
    input wire logic [gpa_pkg::PORT_W-1:0] oe_ctrl,
    input wire logic [gpa_pkg::PORT_W-1:0] fsel_first,
    input wire logic [gpa_pkg::PORT_W-1:0] fsel_second,
    input wire logic [gpa_pkg::PORT_W-1:0] open_drain,
    input wire logic [gpa_pkg::PORT_W-1:0] in_enable,
    input wire logic drive_in_stop,
    input wire logic stop_mode,
    input wire logic [gpa_pkg::PORT_W-1:0] alt_first_out,
    input wire logic [gpa_pkg::PORT_W-1:0] alt_second_out,
    output logic [gpa_pkg::PORT_W-1:0] out_next,
    output logic [gpa_pkg::PORT_W-1:0] oe_next,
    output logic [gpa_pkg::PORT_W-1:0] in_active,
    output logic [gpa_pkg::PORT_W-1:0] int_active
);
    wire stop_cut;

    assign stop_cut = stop_mode & ~drive_in_stop;

    for (genvar i = 0; i < gpa_pkg::PORT_W; i++) begin : g_pin
        wire sel_val;
        // Alternate function wins over port data
        assign sel_val = fsel_first[i] ? alt_first_out[i] : (fsel_second[i] ? alt_second_out[i] : data_bits[i]);
        assign out_next[i] = sel_val;
        // Open drain releases the pin for a high level
        assign oe_next[i] = oe_ctrl[i] & ~stop_cut & ~(open_drain[i] & sel_val);
        assign in_active[i] = in_enable[i] & ~stop_cut;
        // Interrupt pins pass regardless of function select outside stop
        assign int_active[i] = in_enable[i] & gpa_pkg::INT_PIN_MASK[i]
            & (~stop_mode | drive_in_stop | fsel_second[i]);
    end
endmodule

//--- hw/gpa_port.sv
// General-purpose port A with AXI4-Lite register access
`timescale 1ns/1ns
//
// Notes on behaviour
// - Eight pins, each independently an input or an output.
// - Data register holds output values and reads back port values on input-enabled pins, its own bits on the others.
// - A pin drives only while its output enable bit is set.
// - A one in a function select bit routes the pin to its alternate function.
// - Two select bits per pin, the second held at zero on pins 1 and 3; both zero means general-purpose port.
// - Open-drain bit disables the output buffer for high levels.
// - Separate pull-up and pull-down enables per pin.
// - Input enable gates sampling; all inputs off after reset.
// - Reset leaves every pin a port with input, output and pulls off.
// - Stop with drive bit one keeps enabled inputs and outputs working.
// - Stop with drive bit zero turns off inputs and outputs.
// - Enabled interrupt pins with the second select bit set keep their input alive in stop.
// - Outside stop, enabled interrupt inputs pass regardless of function select.
// - Registers decode at fixed offsets from the port base.
// - Output enable bit zero disables, one enables.
module gpa_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [gpa_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [gpa_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [gpa_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [gpa_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stop_mode,
    input wire logic [gpa_pkg::PORT_W-1:0] pin_in,
    output logic [gpa_pkg::PORT_W-1:0] pin_out,
    output logic [gpa_pkg::PORT_W-1:0] pin_oe,
    output logic [gpa_pkg::PORT_W-1:0] pull_up_en,
    output logic [gpa_pkg::PORT_W-1:0] pull_down_en,
    input wire logic [gpa_pkg::PORT_W-1:0] alt_first_out,
    input wire logic [gpa_pkg::PORT_W-1:0] alt_second_out,
    output logic [gpa_pkg::PORT_W-1:0] alt_first_in,
    output logic [gpa_pkg::PORT_W-1:0] alt_second_in,
    output logic [gpa_pkg::PORT_W-1:0] ext_int_in
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] data_reg;
    logic [7:0] output_enable_reg;
    logic [7:0] fsel_first_reg;
    logic [7:0] fsel_second_reg;
    logic [7:0] open_drain_reg;
    logic [7:0] pull_up_reg;
    logic [7:0] pull_down_reg;
    logic [7:0] input_enable_reg;
    logic drive_stop_reg;
    logic [7:0] sample_reg;
    logic aw_full_reg;
    logic w_full_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic w_strb0_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [7:0] pin_out_reg;
    logic [7:0] pin_oe_reg;
    logic [7:0] alt_first_in_reg;
    logic [7:0] alt_second_in_reg;
    logic [7:0] ext_int_reg;
    wire [7:0] out_next;
    wire [7:0] oe_next;
    wire [7:0] in_active;
    wire [7:0] int_active;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel handshake
    wire aw_take;
    wire w_take;
    wire do_write;
    wire aw_full_next;
    wire w_full_next;
    wire bvalid_next;
    wire wr_byte0;
    wire wr_hit;

    assign aw_take = s_axi_awvalid & awready_reg;
    assign w_take = s_axi_wvalid & wready_reg;
    assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign aw_full_next = aw_take | (aw_full_reg & ~do_write);
    assign w_full_next = w_take | (w_full_reg & ~do_write);
    assign bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
    assign wr_byte0 = do_write & w_strb0_reg;

    // Write decode
    wire wr_data;
    wire wr_oe;
    wire wr_fs1;
    wire wr_fs2;
    wire wr_od;
    wire wr_pu;
    wire wr_pd;
    wire wr_ie;
    wire wr_stop;

    assign wr_data = wr_byte0 && aw_addr_reg == gpa_pkg::OFS_PIN_DATA;
    assign wr_oe = wr_byte0 && aw_addr_reg == gpa_pkg::OFS_OUTPUT_ENABLE;
    assign wr_fs1 = wr_byte0 && aw_addr_reg == gpa_pkg::OFS_FSEL_FIRST;
    assign wr_fs2 = wr_byte0 && aw_addr_reg == gpa_pkg::OFS_FSEL_SECOND;
    assign wr_od = wr_byte0 && aw_addr_reg == gpa_pkg::OFS_OPEN_DRAIN;
    assign wr_pu = wr_byte0 && aw_addr_reg == gpa_pkg::OFS_PULL_UP;
    assign wr_pd = wr_byte0 && aw_addr_reg == gpa_pkg::OFS_PULL_DOWN;
    assign wr_ie = wr_byte0 && aw_addr_reg == gpa_pkg::OFS_INPUT_ENABLE;
    assign wr_stop = wr_byte0 && aw_addr_reg == gpa_pkg::OFS_STOP_CONTROL;
    assign wr_hit = aw_addr_reg == gpa_pkg::OFS_PIN_DATA || aw_addr_reg == gpa_pkg::OFS_OUTPUT_ENABLE
        || aw_addr_reg == gpa_pkg::OFS_FSEL_FIRST || aw_addr_reg == gpa_pkg::OFS_FSEL_SECOND
        || aw_addr_reg == gpa_pkg::OFS_OPEN_DRAIN || aw_addr_reg == gpa_pkg::OFS_PULL_UP
        || aw_addr_reg == gpa_pkg::OFS_PULL_DOWN || aw_addr_reg == gpa_pkg::OFS_INPUT_ENABLE
        || aw_addr_reg == gpa_pkg::OFS_STOP_CONTROL;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= gpa_pkg::RESP_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awready_reg <= ~aw_full_next & ~bvalid_next;
            wready_reg <= ~w_full_next & ~bvalid_next;
            bvalid_reg <= bvalid_next;
            if (do_write) begin
                bresp_reg <= wr_hit ? gpa_pkg::RESP_OKAY : gpa_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb0_reg <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take) begin
                w_data_reg <= s_axi_wdata;
                w_strb0_reg <= s_axi_wstrb[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel
    wire ar_take;
    wire rvalid_next;
    wire [7:0] rd_addr;
    wire [7:0] data_view;
    wire [7:0] stop_view;
    logic [7:0] rd_byte;
    logic rd_hit;

    assign ar_take = s_axi_arvalid & arready_reg;
    assign rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
    assign rd_addr = {s_axi_araddr[7:2], 2'b00};
    assign data_view = (input_enable_reg & sample_reg) | (~input_enable_reg & data_reg);
    assign stop_view = {6'h00, stop_mode, drive_stop_reg};

    always_comb begin
        rd_hit = 1'b1;
        case (rd_addr)
            gpa_pkg::OFS_PIN_DATA: rd_byte = data_view;
            gpa_pkg::OFS_OUTPUT_ENABLE: rd_byte = output_enable_reg;
            gpa_pkg::OFS_FSEL_FIRST: rd_byte = fsel_first_reg;
            gpa_pkg::OFS_FSEL_SECOND: rd_byte = fsel_second_reg;
            gpa_pkg::OFS_OPEN_DRAIN: rd_byte = open_drain_reg;
            gpa_pkg::OFS_PULL_UP: rd_byte = pull_up_reg;
            gpa_pkg::OFS_PULL_DOWN: rd_byte = pull_down_reg;
            gpa_pkg::OFS_INPUT_ENABLE: rd_byte = input_enable_reg;
            gpa_pkg::OFS_STOP_CONTROL: rd_byte = stop_view;
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= gpa_pkg::RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_take) begin
                rdata_reg <= {24'h000000, rd_byte};
                rresp_reg <= rd_hit ? gpa_pkg::RESP_OKAY : gpa_pkg::RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_reg <= gpa_pkg::PORT_RESET;
            output_enable_reg <= gpa_pkg::PORT_RESET;
            fsel_first_reg <= gpa_pkg::PORT_RESET;
            fsel_second_reg <= gpa_pkg::PORT_RESET;
            open_drain_reg <= gpa_pkg::PORT_RESET;
            pull_up_reg <= gpa_pkg::PORT_RESET;
            pull_down_reg <= gpa_pkg::PORT_RESET;
            input_enable_reg <= gpa_pkg::PORT_RESET;
            drive_stop_reg <= 1'b0;
        end else begin
            if (wr_data) begin
                data_reg <= w_data_reg[7:0];
            end
            if (wr_oe) begin
                output_enable_reg <= w_data_reg[7:0];
            end
            if (wr_fs1) begin
                fsel_first_reg <= w_data_reg[7:0];
            end
            if (wr_fs2) begin
                fsel_second_reg <= w_data_reg[7:0] & gpa_pkg::FSEL_SECOND_MASK;
            end
            if (wr_od) begin
                open_drain_reg <= w_data_reg[7:0];
            end
            if (wr_pu) begin
                pull_up_reg <= w_data_reg[7:0];
            end
            if (wr_pd) begin
                pull_down_reg <= w_data_reg[7:0];
            end
            if (wr_ie) begin
                input_enable_reg <= w_data_reg[7:0];
            end
            if (wr_stop) begin
                drive_stop_reg <= w_data_reg[gpa_pkg::STOP_DRIVE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin logic
    gpa_pin_mux u_pin_mux (
        .data_bits(data_reg),
        .oe_ctrl(output_enable_reg),
        .fsel_first(fsel_first_reg),
        .fsel_second(fsel_second_reg),
        .open_drain(open_drain_reg),
        .in_enable(input_enable_reg),
        .drive_in_stop(drive_stop_reg),
        .stop_mode(stop_mode),
        .alt_first_out(alt_first_out),
        .alt_second_out(alt_second_out),
        .out_next(out_next),
        .oe_next(oe_next),
        .in_active(in_active),
        .int_active(int_active)
    );

    // Registered pin and peripheral signals, one bit per pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_reg <= 8'h00;
            pin_oe_reg <= 8'h00;
            sample_reg <= 8'h00;
            alt_first_in_reg <= 8'h00;
            alt_second_in_reg <= 8'h00;
            ext_int_reg <= 8'h00;
        end else begin
            pin_out_reg <= out_next;
            pin_oe_reg <= oe_next;
            sample_reg <= pin_in & in_active;
            alt_first_in_reg <= pin_in & in_active & fsel_first_reg;
            alt_second_in_reg <= pin_in & in_active & fsel_second_reg;
            ext_int_reg <= pin_in & int_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
    assign pull_up_en = pull_up_reg;
    assign pull_down_en = pull_down_reg;
    assign alt_first_in = alt_first_in_reg;
    assign alt_second_in = alt_second_in_reg;
    assign ext_int_in = ext_int_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_write_offered;
        s_axi_awvalid && s_axi_awready ##[0:4] (w_full_reg && aw_full_reg);
    endsequence

    sequence s_write_answered;
        ##[1:2] s_axi_bvalid;
    endsequence

    chk_oe_gate: assert property ((pin_oe & ~$past(output_enable_reg)) == 8'h00)
        else $error("pin driven without output enable");

    chk_od_high: assert property ((pin_oe & pin_out & $past(open_drain_reg)) == 8'h00)
        else $error("open drain pin driven high");

    chk_stop_off: assert property ($past(stop_mode & ~drive_stop_reg) |-> pin_oe == 8'h00
        && alt_first_in == 8'h00)
        else $error("pin active in stop without drive");

    chk_stop_int: assert property ($past(stop_mode & ~drive_stop_reg) |->
        (ext_int_in & ~$past(fsel_second_reg & input_enable_reg & gpa_pkg::INT_PIN_MASK)) == 8'h00)
        else $error("unselected interrupt passed in stop");

    chk_input_gate: assert property (((ext_int_in | alt_first_in | alt_second_in)
        & ~$past(input_enable_reg)) == 8'h00)
        else $error("input passed while disabled");

    chk_int_pass: assert property ($past(~stop_mode) |->
        ext_int_in == ($past(pin_in & input_enable_reg) & gpa_pkg::INT_PIN_MASK))
        else $error("interrupt input not passed outside stop");

    chk_reset_state: assert property ($past(!aresetn) |-> pin_oe == 8'h00
        && pull_up_en == 8'h00 && pull_down_en == 8'h00 && ext_int_in == 8'h00)
        else $error("pins not idle after reset");

    chk_gp_drive: assert property (((pin_out ^ $past(data_reg))
        & $past(~fsel_first_reg & ~fsel_second_reg)) == 8'h00)
        else $error("port pin value differs from data");

    chk_alt_route: assert property (((pin_out ^ $past(alt_first_out))
        & $past(fsel_first_reg)) == 8'h00)
        else $error("alternate function not routed");

    chk_stop_keep: assert property ($past(stop_mode & drive_stop_reg) |->
        pin_oe == $past(output_enable_reg & ~(open_drain_reg & out_next)))
        else $error("enabled pin dropped in stop with drive");

    chk_write_resp: assert property (s_write_offered |-> s_write_answered)
        else $error("write response missing");

    chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
endmodule

//--- testbench/gpa_board_model.sv
// Board-side model of the eight port pins
`timescale 1ns/1ns
module gpa_board_model (
    input wire logic aclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] pull_down_en,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    logic [7:0] wiggle_reg = 8'h5A;
    always_ff @(posedge aclk) begin
        wiggle_reg <= ~wiggle_reg;
    end
    // Driven pin wins, then the board, then the pulls, else a changing level
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (pin_oe[b]) begin
                pin_in[b] = pin_out[b];
            end else if (ext_en[b]) begin
                pin_in[b] = ext_val[b];
            end else if (pull_up_en[b]) begin
                pin_in[b] = 1'b1;
            end else if (pull_down_en[b]) begin
                pin_in[b] = 1'b0;
            end else begin
                pin_in[b] = wiggle_reg[b];
            end
        end
    end
endmodule

//--- testbench/gpa_port_tb.sv
// Self-checking bench for port A
`timescale 1ns/1ns
module gpa_port_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic stop_mode = 1'b0;
    logic [7:0] alt1 = 8'h00, alt2 = 8'h00, ext_val = 8'h00, ext_en = 8'hFF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [7:0] pin_in, pin_out, pin_oe, pu, pd, a1_in, a2_in, ext_int;
    logic [7:0] v [8];
    logic [7:0] offs [8];
    logic [7:0] val, eoe, lvl, act;
    int error_cnt = 0, check_count = 0, st;
    always #10 aclk = ~aclk;
    gpa_port DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .stop_mode(stop_mode),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pu), .pull_down_en(pd),
        .alt_first_out(alt1), .alt_second_out(alt2), .alt_first_in(a1_in), .alt_second_in(a2_in),
        .ext_int_in(ext_int));
    gpa_board_model board (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pu),
        .pull_down_en(pd), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw, w, ta, tw;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w) begin
            @(negedge aclk);
            ta = aw && awready;
            tw = w && wready;
            @(posedge aclk);
            if (ta) begin
                awvalid <= 1'b0;
                aw = 1'b0;
            end
            if (tw) begin
                wvalid <= 1'b0;
                w = 1'b0;
            end
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge aclk);
    endtask
    task automatic axi_read(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        @(posedge aclk);
    endtask
    function automatic logic [7:0] mux_val(input logic [7:0] d, f1, f2, a1, a2);
        return (f1 & a1) | (~f1 & f2 & a2) | (~f1 & ~f2 & d);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(20 * 30000);
        error_cnt++;
        conclude();
    end
    initial begin
        offs = '{gpa_pkg::OFS_PIN_DATA, gpa_pkg::OFS_OUTPUT_ENABLE, gpa_pkg::OFS_FSEL_FIRST,
            gpa_pkg::OFS_FSEL_SECOND, gpa_pkg::OFS_OPEN_DRAIN, gpa_pkg::OFS_PULL_UP,
            gpa_pkg::OFS_PULL_DOWN, gpa_pkg::OFS_INPUT_ENABLE};
        void'($urandom(32'h48e17fb5));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 8; k++) begin
            axi_read(offs[k]);
            check("reset value", rd, 32'h00000000);
        end
        check("reset drive", {pin_oe, pu, pd, a1_in}, 32'h00000000);
        axi_read(8'h10);
        check("unmapped read", {rd[29:0], resp}, {30'h0, gpa_pkg::RESP_SLVERR});
        axi_write(8'h10, 32'h000000FF, 4'hF);
        check("unmapped write", resp, gpa_pkg::RESP_SLVERR);
        axi_write(gpa_pkg::OFS_OUTPUT_ENABLE, 32'h000000FF, 4'h0);
        axi_read(gpa_pkg::OFS_OUTPUT_ENABLE);
        check("strobe off", rd, 32'h00000000);
        for (int i = 0; i < 12; i++) begin
            stop_mode <= 1'b0;
            for (int k = 0; k < 8; k++) begin
                v[k] = 8'($urandom);
            end
            if (i == 0) begin
                v = '{8'hA5, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h0F, 8'hF0, 8'hFF};
            end
            v[3] = v[3] & ~v[2];
            alt1 <= 8'($urandom);
            alt2 <= 8'($urandom);
            ext_val <= 8'($urandom);
            // Board leaves only pulled pins undriven, so every level is known
            ext_en <= 8'($urandom) | ~(v[5] | v[6]);
            for (int k = 0; k < 8; k++) begin
                axi_write(offs[k], {24'h0, v[k]}, 4'hF);
                check("write resp", resp, gpa_pkg::RESP_OKAY);
            end
            for (int k = 1; k < 8; k++) begin
                axi_read(offs[k]);
                check("readback", rd, {24'h0, (k == 3) ? (v[k] & gpa_pkg::FSEL_SECOND_MASK) : v[k]});
            end
            v[3] = v[3] & gpa_pkg::FSEL_SECOND_MASK;
            st = i % 3;
            axi_write(gpa_pkg::OFS_STOP_CONTROL, {31'h0, st == 2}, 4'hF);
            stop_mode <= (st != 0);
            repeat (4) @(posedge aclk);
            @(negedge aclk);
            val = mux_val(v[0], v[2], v[3], alt1, alt2);
            eoe = v[1] & ~(v[4] & val) & ((st == 1) ? 8'h00 : 8'hFF);
            lvl = (eoe & val) | (~eoe & ((ext_en & ext_val) | (~ext_en & v[5])));
            check("pin drive enable", pin_oe, eoe);
            check("pin value", pin_out & eoe, val & eoe);
            check("pulls", {pu, pd}, {v[5], v[6]});
            act = lvl & v[7] & gpa_pkg::INT_PIN_MASK;
            check("interrupt pass", ext_int, (st == 1) ? (act & v[3]) : act);
            if (st == 1) begin
                check("inputs off in stop", {a1_in, a2_in}, 16'h0000);
            end else begin
                check("alternate inputs", {a1_in, a2_in}, {lvl & v[7] & v[2], lvl & v[7] & v[3]});
                axi_read(gpa_pkg::OFS_PIN_DATA);
                check("port value", rd, {24'h0, (lvl & v[7]) | (v[0] & ~v[7])});
            end
            axi_read(gpa_pkg::OFS_STOP_CONTROL);
            check("stop control", rd, {30'h0, st != 0, st == 2});
        end
        conclude();
    end
endmodule
